// >>> irbm_pkg.sv
package irbm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    ////////////////////////////////////////////////////////////////////////////
    // monitor word byte addresses
    localparam logic [7:0] OFS_SEL_MON0 = 8'h00;
    localparam logic [7:0] OFS_SEL_MON1 = 8'h04;
    localparam logic [7:0] OFS_SEL_MON2 = 8'h08;
    localparam logic [7:0] OFS_SEL_MON3 = 8'h0c;
    localparam logic [7:0] OFS_SEL_MON4 = 8'h10;
    localparam logic [7:0] OFS_SEL_MON5 = 8'h14;
    localparam logic [7:0] OFS_SEL_MON6 = 8'h18;
    localparam logic [7:0] OFS_SEL_MON7 = 8'h1c;
    localparam logic [7:0] OFS_MOTOR0_MON = 8'h20;
    localparam logic [7:0] OFS_MOTOR1_MON = 8'h24;
    localparam logic [7:0] OFS_MOTOR2_MON = 8'h28;
    localparam logic [7:0] OFS_EXT_LOW_MON = 8'h2c;
    localparam logic [7:0] OFS_EXT_HIGH_MON = 8'h30;
    localparam logic [7:0] OFS_QUAD_MON = 8'h34;

    ////////////////////////////////////////////////////////////////////////////
    // control and event registers
    localparam logic [7:0] OFS_SELECTOR0 = 8'h40;
    localparam logic [7:0] OFS_SELECTOR1 = 8'h44;
    localparam logic [7:0] OFS_DMA_ROUTE = 8'h48;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h50;
    localparam logic [7:0] OFS_EVT_MASK = 8'h54;

    localparam logic [31:0] SELECTOR_RST = 32'h0000_0000;
    localparam logic [31:0] DMA_ROUTE_RST = 32'h0000_0000;
    localparam logic [31:0] READ_IDLE = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // selectable-source monitors
    localparam int unsigned SEL_CHANNELS = 8;
    localparam int unsigned SEL_FIELD_W = 8;
    localparam int unsigned NUM_SEL_SRC = 32;
    localparam logic [31:0] BASE_TIMER_SRC_MASK = 32'h0000_00ff;

    ////////////////////////////////////////////////////////////////////////////
    // motor-control word layout
    localparam int unsigned MOTOR_UNITS = 3;
    localparam int unsigned MOTOR_STS_BIT = 6;
    localparam int unsigned MOTOR_TX_BIT = 5;
    localparam int unsigned MOTOR_RX_BIT = 4;
    localparam int unsigned MOTOR_WAVE54_BIT = 3;
    localparam int unsigned MOTOR_WAVE32_BIT = 2;
    localparam int unsigned MOTOR_WAVE10_BIT = 1;
    localparam int unsigned MOTOR_ESTOP_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // external channel split
    localparam int unsigned EXT_CHANNELS = 32;
    localparam int unsigned EXT_LOW_COUNT = 8;
    localparam int unsigned EXT_HIGH_COUNT = 24;
    localparam int unsigned EXT_DRQ_LSB = 28;
    localparam int unsigned EXT_DRQ_COUNT = 4;

    ////////////////////////////////////////////////////////////////////////////
    // quadrature decoder / dual timer word layout
    localparam int unsigned QUAD_BOTH_MATCH_BIT = 7;
    localparam int unsigned QUAD_REV_RANGE_BIT = 6;
    localparam int unsigned QUAD_DIR_INV_BIT = 5;
    localparam int unsigned QUAD_OVF_ZERO_BIT = 4;
    localparam int unsigned QUAD_COMB_MATCH_BIT = 3;
    localparam int unsigned QUAD_POS_MATCH_BIT = 2;
    localparam int unsigned TIMER_SECOND_BIT = 1;
    localparam int unsigned TIMER_FIRST_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // one event per monitor word
    localparam int unsigned NUM_MON = 14;
    localparam int unsigned EVT_MOTOR0 = 8;
    localparam int unsigned EVT_EXT_LOW = 11;
    localparam int unsigned EVT_EXT_HIGH = 12;
    localparam int unsigned EVT_QUAD = 13;

endpackage : irbm_pkg

// >>> irbm_source_select.sv
`timescale 1ns/1ps
module irbm_source_select #(
    parameter int unsigned NUM_SRC = 32,
    parameter int unsigned CHANNELS = 8,
    parameter int unsigned FIELD_W = 8,
    parameter logic [NUM_SRC-1:0] BT_MASK = '0
) (
    // selector fields, field 0 in the low bits
    input wire logic [CHANNELS*FIELD_W-1:0] selFields,
    // candidate requests
    input wire logic [NUM_SRC-1:0] srcReq,
    input wire logic [NUM_SRC-1:0] srcReqAlt,
    // one live bit per channel
    output logic [CHANNELS-1:0] selReq
);
    localparam int unsigned IDX_W = $clog2(NUM_SRC);

    // base timers raise on either of their two lines
    wire [NUM_SRC-1:0] combined = srcReq | (srcReqAlt & BT_MASK);

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : gSel
            wire [FIELD_W-1:0] field = selFields[g*FIELD_W +: FIELD_W];
            // codes beyond the source table read as no request
            wire inRange = field < FIELD_W'(NUM_SRC);
            wire [IDX_W-1:0] idx = field[IDX_W-1:0];
            assign selReq[g] = inRange & combined[idx];
        end
    endgenerate

endmodule : irbm_source_select

// >>> irbm_event_flags.sv
`timescale 1ns/1ps
module irbm_event_flags #(
    parameter int unsigned N = 14
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // event pulses
    input wire logic [N-1:0] evt,
    // software access
    input wire logic clrWr,
    input wire logic maskWr,
    input wire logic [N-1:0] wrData,
    // state
    output logic [N-1:0] status,
    output logic [N-1:0] mask,
    output logic irq
);
    logic [N-1:0] status_reg;
    logic [N-1:0] mask_reg;

    // a set in the clearing cycle survives
    wire [N-1:0] clrBits = clrWr ? wrData : '0;
    wire [N-1:0] status_next = (status_reg & ~clrBits) | evt;
    wire [N-1:0] mask_next = maskWr ? wrData : mask_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            status_reg <= '0;
            mask_reg <= '0;
        end else begin
            status_reg <= status_next;
            mask_reg <= mask_next;
        end
    end

    assign status = status_reg;
    assign mask = mask_reg;
    assign irq = |(status_reg & mask_reg);

endmodule : irbm_event_flags

// >>> irbm_monitor.sv
// What this block does
// - eight selectable monitors for vectors 19..26, bit 0 is the selected request
// - monitors 0..3 use fields 0..3 of selector 0, 4..7 fields of selector 1
// - a selected base timer reads 1 if either of its two requests is high
// - reserved bits above each defined field always read zero
// - motor monitors for vectors 27, 55, 56: units 0,1,2 with serial 8,14,15
// - motor word bits 6,5,4 are serial status, transmit, receive requests
// - motor word bits 3,2,1 are waveform pairs 54,32,10; bit 0 emergency stop
// - vector 28 word shows external channels 0..7 on bits 0..7
// - an external channel routed to DMA reads 0 in its monitor
// - vector 29 word shows external channels 8..31 on bits 0..23
// - vector 30 bits 7..2 show the six quadrature decoder requests in order
// - vector 30 bits 1 and 0 show dual timer second and first requests
// - routing bit of 1 sends the source to DMA instead of the processor
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
module irbm_monitor #(
    parameter int unsigned NUM_SEL_SRC = irbm_pkg::NUM_SEL_SRC,
    parameter logic [31:0] BT_SRC_MASK = irbm_pkg::BASE_TIMER_SRC_MASK
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register port
    input wire logic [irbm_pkg::ADDR_W-1:0] regAddr,
    input wire logic [irbm_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [irbm_pkg::DATA_W-1:0] regRdData,
    // selectable sources
    input wire logic [NUM_SEL_SRC-1:0] selSrcReq,
    input wire logic [NUM_SEL_SRC-1:0] selSrcReqAlt,
    // motor-control units, index = unit
    input wire logic [irbm_pkg::MOTOR_UNITS-1:0] serialStsReq,
    input wire logic [irbm_pkg::MOTOR_UNITS-1:0] serialTxReq,
    input wire logic [irbm_pkg::MOTOR_UNITS-1:0] serialRxReq,
    input wire logic [irbm_pkg::MOTOR_UNITS-1:0] wave54Req,
    input wire logic [irbm_pkg::MOTOR_UNITS-1:0] wave32Req,
    input wire logic [irbm_pkg::MOTOR_UNITS-1:0] wave10Req,
    input wire logic [irbm_pkg::MOTOR_UNITS-1:0] motorEmergencyStop,
    // external pin requests
    input wire logic [irbm_pkg::EXT_CHANNELS-1:0] extPinReq,
    // quadrature decoder channel 0
    input wire logic quadBothMatchReq,
    input wire logic quadRevRangeReq,
    input wire logic quadDirInvertReq,
    input wire logic quadOvfZeroReq,
    input wire logic quadCombMatchReq,
    input wire logic quadPosMatchReq,
    // dual timer
    input wire logic dualTimerFirstReq,
    input wire logic dualTimerSecondReq,
    // routed-out requests
    output logic [irbm_pkg::EXT_DRQ_COUNT-1:0] extDmaReq,
    output logic [irbm_pkg::EXT_CHANNELS-1:0] extCpuReq,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // software-written control

    logic [31:0] selector0_reg;
    logic [31:0] selector1_reg;
    logic [31:0] dmaRoute_reg;
    logic [31:0] rdData_reg;
    logic [irbm_pkg::NUM_MON-1:0] nonzero_reg;

    wire hitSel0 = regAddr == irbm_pkg::OFS_SELECTOR0;
    wire hitSel1 = regAddr == irbm_pkg::OFS_SELECTOR1;
    wire hitRoute = regAddr == irbm_pkg::OFS_DMA_ROUTE;
    wire hitStatus = regAddr == irbm_pkg::OFS_EVT_STATUS;
    wire hitMask = regAddr == irbm_pkg::OFS_EVT_MASK;

    wire [31:0] selector0_next = (regWr && hitSel0) ? regWrData : selector0_reg;
    wire [31:0] selector1_next = (regWr && hitSel1) ? regWrData : selector1_reg;
    wire [31:0] dmaRoute_next = (regWr && hitRoute) ? regWrData : dmaRoute_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            selector0_reg <= irbm_pkg::SELECTOR_RST;
            selector1_reg <= irbm_pkg::SELECTOR_RST;
            dmaRoute_reg <= irbm_pkg::DMA_ROUTE_RST;
        end else begin
            selector0_reg <= selector0_next;
            selector1_reg <= selector1_next;
            dmaRoute_reg <= dmaRoute_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // selectable-source monitors

    logic [irbm_pkg::SEL_CHANNELS-1:0] selReq;

    // fields 0..3 live in selector 0, fields 4..7 in selector 1
    wire [63:0] selFields = {selector1_reg, selector0_reg};

    irbm_source_select #(
        .NUM_SRC(NUM_SEL_SRC),
        .CHANNELS(irbm_pkg::SEL_CHANNELS),
        .FIELD_W(irbm_pkg::SEL_FIELD_W),
        .BT_MASK(BT_SRC_MASK[NUM_SEL_SRC-1:0])
    ) uSelect (
        .selFields(selFields),
        .srcReq(selSrcReq),
        .srcReqAlt(selSrcReqAlt),
        .selReq(selReq)
    );

    logic [31:0] selWord [irbm_pkg::SEL_CHANNELS];

    genvar s;
    generate
        for (s = 0; s < irbm_pkg::SEL_CHANNELS; s = s + 1) begin : gSelWord
            assign selWord[s] = {31'h0000_0000, selReq[s]};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // motor-control monitors

    logic [31:0] motorWord [irbm_pkg::MOTOR_UNITS];

    genvar m;
    generate
        for (m = 0; m < irbm_pkg::MOTOR_UNITS; m = m + 1) begin : gMotor
            logic [6:0] field;
            always_comb begin
                field = 7'h00;
                field[irbm_pkg::MOTOR_STS_BIT] = serialStsReq[m];
                field[irbm_pkg::MOTOR_TX_BIT] = serialTxReq[m];
                field[irbm_pkg::MOTOR_RX_BIT] = serialRxReq[m];
                field[irbm_pkg::MOTOR_WAVE54_BIT] = wave54Req[m];
                field[irbm_pkg::MOTOR_WAVE32_BIT] = wave32Req[m];
                field[irbm_pkg::MOTOR_WAVE10_BIT] = wave10Req[m];
                field[irbm_pkg::MOTOR_ESTOP_BIT] = motorEmergencyStop[m];
            end
            assign motorWord[m] = {25'h000_0000, field};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // external channels and their DMA routing

    logic [irbm_pkg::EXT_CHANNELS-1:0] extRouteMask;

    genvar e;
    generate
        for (e = 0; e < irbm_pkg::EXT_CHANNELS; e = e + 1) begin : gExt
            if (e < irbm_pkg::EXT_DRQ_COUNT) begin : gRoutable
                // routed channels leave the processor path entirely
                assign extRouteMask[e] = dmaRoute_reg[irbm_pkg::EXT_DRQ_LSB + e];
                assign extDmaReq[e] = extPinReq[e] & extRouteMask[e];
            end else begin : gFixed
                assign extRouteMask[e] = 1'b0;
            end
        end
    endgenerate

    assign extCpuReq = extPinReq & ~extRouteMask;

    wire [31:0] extLowWord = {24'h00_0000, extCpuReq[irbm_pkg::EXT_LOW_COUNT-1:0]};
    wire [31:0] extHighWord = {8'h00, extCpuReq[irbm_pkg::EXT_CHANNELS-1:
        irbm_pkg::EXT_LOW_COUNT]};

    ////////////////////////////////////////////////////////////////////////////
    // quadrature decoder and dual timer monitor

    logic [7:0] quadField;

    always_comb begin
        quadField = 8'h00;
        quadField[irbm_pkg::QUAD_BOTH_MATCH_BIT] = quadBothMatchReq;
        quadField[irbm_pkg::QUAD_REV_RANGE_BIT] = quadRevRangeReq;
        quadField[irbm_pkg::QUAD_DIR_INV_BIT] = quadDirInvertReq;
        quadField[irbm_pkg::QUAD_OVF_ZERO_BIT] = quadOvfZeroReq;
        quadField[irbm_pkg::QUAD_COMB_MATCH_BIT] = quadCombMatchReq;
        quadField[irbm_pkg::QUAD_POS_MATCH_BIT] = quadPosMatchReq;
        quadField[irbm_pkg::TIMER_SECOND_BIT] = dualTimerSecondReq;
        quadField[irbm_pkg::TIMER_FIRST_BIT] = dualTimerFirstReq;
    end

    wire [31:0] quadWord = {24'h00_0000, quadField};

    ////////////////////////////////////////////////////////////////////////////
    // events: a monitor word going from all-zero to nonzero

    logic [irbm_pkg::NUM_MON-1:0] nonzero;
    logic [irbm_pkg::NUM_MON-1:0] evtStatus;
    logic [irbm_pkg::NUM_MON-1:0] evtMask;

    genvar n;
    generate
        for (n = 0; n < irbm_pkg::SEL_CHANNELS; n = n + 1) begin : gNzSel
            assign nonzero[n] = |selWord[n];
        end
        for (n = 0; n < irbm_pkg::MOTOR_UNITS; n = n + 1) begin : gNzMotor
            assign nonzero[irbm_pkg::EVT_MOTOR0 + n] = |motorWord[n];
        end
    endgenerate

    assign nonzero[irbm_pkg::EVT_EXT_LOW] = |extLowWord;
    assign nonzero[irbm_pkg::EVT_EXT_HIGH] = |extHighWord;
    assign nonzero[irbm_pkg::EVT_QUAD] = |quadWord;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            nonzero_reg <= '0;
        end else begin
            nonzero_reg <= nonzero;
        end
    end

    wire [irbm_pkg::NUM_MON-1:0] evtRise = nonzero & ~nonzero_reg;

    irbm_event_flags #(
        .N(irbm_pkg::NUM_MON)
    ) uFlags (
        .clock(clock),
        .sys_rst(sys_rst),
        .evt(evtRise),
        .clrWr(regWr && hitStatus),
        .maskWr(regWr && hitMask),
        .wrData(regWrData[irbm_pkg::NUM_MON-1:0]),
        .status(evtStatus),
        .mask(evtMask),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read path; monitor offsets take no writes and reads have no side effect

    logic [31:0] rdMux;

    always_comb begin
        case (regAddr)
            irbm_pkg::OFS_SEL_MON0: rdMux = selWord[0];
            irbm_pkg::OFS_SEL_MON1: rdMux = selWord[1];
            irbm_pkg::OFS_SEL_MON2: rdMux = selWord[2];
            irbm_pkg::OFS_SEL_MON3: rdMux = selWord[3];
            irbm_pkg::OFS_SEL_MON4: rdMux = selWord[4];
            irbm_pkg::OFS_SEL_MON5: rdMux = selWord[5];
            irbm_pkg::OFS_SEL_MON6: rdMux = selWord[6];
            irbm_pkg::OFS_SEL_MON7: rdMux = selWord[7];
            irbm_pkg::OFS_MOTOR0_MON: rdMux = motorWord[0];
            irbm_pkg::OFS_MOTOR1_MON: rdMux = motorWord[1];
            irbm_pkg::OFS_MOTOR2_MON: rdMux = motorWord[2];
            irbm_pkg::OFS_EXT_LOW_MON: rdMux = extLowWord;
            irbm_pkg::OFS_EXT_HIGH_MON: rdMux = extHighWord;
            irbm_pkg::OFS_QUAD_MON: rdMux = quadWord;
            irbm_pkg::OFS_SELECTOR0: rdMux = selector0_reg;
            irbm_pkg::OFS_SELECTOR1: rdMux = selector1_reg;
            irbm_pkg::OFS_DMA_ROUTE: rdMux = dmaRoute_reg;
            irbm_pkg::OFS_EVT_STATUS: rdMux = {18'h0_0000, evtStatus};
            irbm_pkg::OFS_EVT_MASK: rdMux = {18'h0_0000, evtMask};
            default: rdMux = irbm_pkg::READ_IDLE;
        endcase
    end

    // data stands only in the cycle after the strobe
    wire [31:0] rdData_next = regRd ? rdMux : irbm_pkg::READ_IDLE;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_reg <= irbm_pkg::READ_IDLE;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    assign regRdData = rdData_reg;

endmodule : irbm_monitor

// >>> irbm_monitor_sva.sv
`timescale 1ns/1ps
module irbm_monitor_sva (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    // motor unit requests
    input wire logic [2:0] serialStsReq,
    input wire logic [2:0] serialTxReq,
    input wire logic [2:0] serialRxReq,
    input wire logic [2:0] wave54Req,
    input wire logic [2:0] wave32Req,
    input wire logic [2:0] wave10Req,
    input wire logic [2:0] motorEmergencyStop,
    // external channels
    input wire logic [31:0] extPinReq,
    input wire logic [3:0] extDmaReq,
    input wire logic [31:0] extCpuReq,
    // quadrature decoder and dual timer
    input wire logic quadBothMatchReq,
    input wire logic quadRevRangeReq,
    input wire logic quadDirInvertReq,
    input wire logic quadOvfZeroReq,
    input wire logic quadCombMatchReq,
    input wire logic quadPosMatchReq,
    input wire logic dualTimerFirstReq,
    input wire logic dualTimerSecondReq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////////
    // live words as seen at the read edge
    logic [6:0] motorPrev;
    logic [7:0] quadPrev;
    logic [31:0] extPrev;
    always_ff @(posedge clock) begin
        motorPrev <= {serialStsReq[0], serialTxReq[0], serialRxReq[0], wave54Req[0],
            wave32Req[0], wave10Req[0], motorEmergencyStop[0]};
        quadPrev <= {quadBothMatchReq, quadRevRangeReq, quadDirInvertReq, quadOvfZeroReq,
            quadCombMatchReq, quadPosMatchReq, dualTimerSecondReq, dualTimerFirstReq};
        extPrev <= extCpuReq;
    end

    ////////////////////////////////////////////////////////////////////////////
    a_read_idle_zero: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data not zero outside read cycle");
    a_unmapped_zero: assert property (regRd && regAddr == 8'hfc |=> regRdData == 32'h0)
        else $error("unmapped read not zero");
    a_sel_upper_zero: assert property (regRd && regAddr <= 8'h1c |=> regRdData[31:1] == 31'h0)
        else $error("selectable monitor reserved bits set");
    a_motor_word: assert property (regRd && regAddr == 8'h20 |=> regRdData == {25'h0, motorPrev})
        else $error("motor monitor word wrong");
    a_ext_low_word: assert property (regRd && regAddr == 8'h2c |=> regRdData == {24'h0, extPrev[7:0]})
        else $error("external low word wrong");
    a_ext_high_word: assert property (regRd && regAddr == 8'h30 |=> regRdData == {8'h0, extPrev[31:8]})
        else $error("external high word wrong");
    a_quad_word: assert property (regRd && regAddr == 8'h34 |=> regRdData == {24'h0, quadPrev})
        else $error("quadrature word wrong");
    a_ext_pass_high: assert property (extCpuReq[31:4] == extPinReq[31:4])
        else $error("unrouted channel altered");
    a_route_split: assert property (((extCpuReq[3:0] | extDmaReq) == extPinReq[3:0]) && ((extCpuReq[3:0] & extDmaReq) == 4'h0))
        else $error("routed channel not exclusive");
endmodule : irbm_monitor_sva

bind irbm_monitor irbm_monitor_sva u_sva (.*);

// >>> irbm_req_source.sv
`timescale 1ns/1ps
module irbm_req_source (
    // clock
    input wire logic clock,
    // request pattern, shown one edge later
    input wire logic [124:0] pattern,
    // request lines
    output logic [31:0] selSrcReq,
    output logic [31:0] selSrcReqAlt,
    output logic [2:0] serialStsReq,
    output logic [2:0] serialTxReq,
    output logic [2:0] serialRxReq,
    output logic [2:0] wave54Req,
    output logic [2:0] wave32Req,
    output logic [2:0] wave10Req,
    output logic [2:0] motorEmergencyStop,
    output logic [31:0] extPinReq,
    output logic [7:0] quadTimerReq
);
    // requests are levels held by the peripherals until their own flags clear
    initial begin
        {quadTimerReq, extPinReq, motorEmergencyStop, wave10Req, wave32Req, wave54Req,
            serialRxReq, serialTxReq, serialStsReq, selSrcReqAlt, selSrcReq} = 125'h0;
    end
    always @(posedge clock) begin
        {quadTimerReq, extPinReq, motorEmergencyStop, wave10Req, wave32Req, wave54Req,
            serialRxReq, serialTxReq, serialStsReq, selSrcReqAlt, selSrcReq} <= pattern;
    end
endmodule : irbm_req_source

// >>> tb_irq_request_batch_monitor.sv
`timescale 1ns/1ps
module tb_irq_request_batch_monitor;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdData, selSrcReq, selSrcReqAlt, extPinReq, extCpuReq;
    logic [2:0] serialStsReq, serialTxReq, serialRxReq, wave54Req, wave32Req, wave10Req;
    logic [2:0] motorEmergencyStop;
    logic [7:0] quadTimerReq;
    logic [3:0] extDmaReq;
    logic irq;
    logic [124:0] pattern = 125'h0;
    logic [31:0] sel0 = 32'h0, sel1 = 32'h0, route = 32'h0, rdVal;
    logic [7:0] ctlAddr [6] = '{8'h40, 8'h44, 8'h48, 8'h50, 8'h54, 8'hfc};
    integer seed = 53;
    integer fails = 0;
    integer n_tests = 0;

    always #12.5 clock = ~clock;

    irbm_req_source u_src (.*);
    irbm_monitor u_dut (.*, .quadBothMatchReq(quadTimerReq[7]), .quadRevRangeReq(quadTimerReq[6]),
        .quadDirInvertReq(quadTimerReq[5]), .quadOvfZeroReq(quadTimerReq[4]),
        .quadCombMatchReq(quadTimerReq[3]), .quadPosMatchReq(quadTimerReq[2]),
        .dualTimerSecondReq(quadTimerReq[1]), .dualTimerFirstReq(quadTimerReq[0]));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk32
    task automatic chk1(input logic got, input logic exp, input string what);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk1
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd
    task automatic setReq(input logic [124:0] v);
        @(posedge clock);
        pattern <= v;
        @(posedge clock);
    endtask : setReq
    task automatic setCfg(input logic [31:0] s0, input logic [31:0] s1, input logic [31:0] r);
        sel0 = s0;
        sel1 = s1;
        route = r;
        wr(irbm_pkg::OFS_SELECTOR0, s0);
        wr(irbm_pkg::OFS_SELECTOR1, s1);
        wr(irbm_pkg::OFS_DMA_ROUTE, r);
    endtask : setCfg

    ////////////////////////////////////////////////////////////////////////////
    // reference view of the fourteen words
    function automatic logic [31:0] extExp();
        return pattern[116:85] & ~{28'h0, route[31:28]};
    endfunction : extExp
    function automatic logic [31:0] expWord(input int i);
        logic [63:0] fields;
        logic [7:0] code;
        logic [31:0] comb;
        int u;
        fields = {sel1, sel0};
        code = fields[8*(i%8) +: 8];
        comb = pattern[31:0] | (pattern[63:32] & irbm_pkg::BASE_TIMER_SRC_MASK);
        u = i - 8;
        if (i < 8) return {31'h0, (code < 8'h20) ? comb[code[4:0]] : 1'b0};
        if (i < 11) return {25'h0, pattern[64+u], pattern[67+u], pattern[70+u], pattern[73+u],
            pattern[76+u], pattern[79+u], pattern[82+u]};
        if (i == 11) return 32'(extExp() & 32'hff);
        if (i == 12) return 32'(extExp() >> 8);
        return {24'h0, pattern[124:117]};
    endfunction : expWord
    task automatic checkAll();
        for (int i = 0; i < 14; i++) begin
            rd(8'(4 * i), rdVal);
            chk32(rdVal, expWord(i), "monitor word");
        end
        chk32(extCpuReq, extExp(), "cpu requests");
        chk32({28'h0, extDmaReq}, {28'h0, pattern[88:85] & route[31:28]}, "dma requests");
    endtask : checkAll
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        fails = fails + 1;
        complete_run();
    end

    initial begin
        logic [127:0] r;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        foreach (ctlAddr[k]) begin
            rd(ctlAddr[k], rdVal);
            chk32(rdVal, 32'h0, "reset or unmapped value");
        end
        checkAll();
        // base timer alt line counts only for base timers; code 63 must not wrap
        setCfg(32'h3f1f0a03, 32'h0, 32'h0);
        setReq({61'h0, 32'h0000_0408, 32'h8000_0000});
        checkAll();
        setCfg(32'h0, 32'h0, 32'hf000_0000);
        setReq({8'h0, 32'hffff_ffff, 85'h0});
        checkAll();
        for (int k = 0; k < 40; k++) begin
            setCfg($random(seed) & 32'h3f3f3f3f, $random(seed) & 32'h3f3f3f3f, $random(seed));
            r = {$random(seed), $random(seed), $random(seed), $random(seed)};
            setReq(r[124:0]);
            wr(8'(4 * (k % 14)), $random(seed));
            checkAll();
        end
        // events: one unmasked, one masked
        setCfg(32'h0, 32'h0, 32'h0);
        setReq(125'h0);
        wr(irbm_pkg::OFS_EVT_STATUS, 32'h3fff);
        wr(irbm_pkg::OFS_EVT_MASK, 32'h1 << irbm_pkg::EVT_EXT_LOW);
        setReq(125'h1 << 90);
        repeat (2) @(posedge clock);
        #1;
        chk1(irq, 1'b1, "irq on enabled event");
        rd(irbm_pkg::OFS_EVT_STATUS, rdVal);
        chk32(rdVal, 32'h1 << irbm_pkg::EVT_EXT_LOW, "status after event");
        wr(irbm_pkg::OFS_EVT_STATUS, 32'h1 << irbm_pkg::EVT_EXT_LOW);
        @(posedge clock);
        #1;
        chk1(irq, 1'b0, "irq after clear");
        setReq(125'h1 << 97);
        repeat (2) @(posedge clock);
        #1;
        chk1(irq, 1'b0, "masked event");
        rd(irbm_pkg::OFS_EVT_STATUS, rdVal);
        chk32(rdVal, 32'h1 << irbm_pkg::EVT_EXT_HIGH, "masked status");
        complete_run();
    end
endmodule : tb_irq_request_batch_monitor
